// ===== core/safety_out_pkg.sv
// Constants for the safety outputs and interrupt block
package safety_out_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ERR_SHORT_TIME_US = 100;
  localparam int ERR_LONG_TIME_US  = 200;
  localparam int INT_BLANK_TIME_US = 500;
  localparam int ERR_SHORT_CYC =
    (ERR_SHORT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int ERR_LONG_CYC  =
    (ERR_LONG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int INT_BLANK_CYC =
    (INT_BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ==========================================================
  // Register offsets (6-bit register address)
  localparam logic [5:0] ADDR_INT_REQ    = 6'h07;
  localparam logic [5:0] ADDR_INT_CLR    = 6'h0b;
  localparam logic [5:0] ADDR_INT_MASK   = 6'h10;
  localparam logic [5:0] ADDR_PIN_LEVEL  = 6'h15;

  // ==========================================================
  // Field positions of pin_level_and_error_mode
  localparam int BIT_IND_LEVEL   = 5;
  localparam int BIT_EXT_LEVEL   = 4;
  localparam int BIT_TOGGLE_SEL  = 1;
  localparam int BIT_ERR_FORMAT  = 0;
  localparam logic [7:0] PIN_LEVEL_RST   = 8'h30;
  localparam logic [7:0] PIN_LEVEL_WMASK = 8'h33;

  // ==========================================================
  // Field positions of the diagnosis interrupt request register
  localparam int BIT_DUMMY       = 7;
  localparam int BIT_FAIL_MON    = 3;
  localparam int BIT_CTL_MON     = 2;
  localparam int BIT_IND_MON     = 1;
  localparam int BIT_RST_MON     = 0;
  localparam logic [7:0] INT_REQ_RST  = 8'h00;
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  localparam logic [7:0] INT_USED     = 8'h8f;

endpackage

// ===== core/safety_outputs_and_interrupt.sv
// Safety status outputs, error input monitor and interrupt output
//
// How it works
// - indicator pin goes low while the I/O rail is below threshold.
// - indicator level bit drives the pin, only after pin first went high.
// - safety-fail output low while either error input shows error.
// - detected error pulls reset low only if its reset option enabled.
// - static format (bit0 clear): low error input counts as error.
// - dynamic format: no toggle for selected timeout counts as error.
// - error monitoring starts only after the input first rose high.
// - safety-fail output held low while reset output is low.
// - control pin goes high once a watchdog start is requested.
// - any reset, expiry included, drives control pin low.
// - in question-answer mode, control pin high only after monitoring.
// - masked expiry drops control pin only, until watchdog restarts.
// - watchdog suspended by rail undervoltage drives control pin low.
// - control level bit drives the pin, only after watchdog started.
// - timeout select bit: set 100 us, clear 200 us, dynamic only.
// - static format uses a fixed 100 us expiry time.
// - factor latches into status and asserts the interrupt output.
// - host clears by writing ones; output stays released once all unmasked factors cleared.
// - masked factors still latch but do not assert the interrupt.
// - after a clear, interrupt stays released 500 us, then reasserts.
// - pin monitors raise diagnosis factors on a pin fault.
// - writable intentional bit raises a factor for connection check.
// - interrupt output active low while unmasked factors are latched.
`timescale 1ns/100ps

module safety_outputs_and_interrupt
  import safety_out_pkg::*;
#(
  parameter int ERR_SHORT_CYCLES = ERR_SHORT_CYC, // 100 us in cycles
  parameter int ERR_LONG_CYCLES  = ERR_LONG_CYC,  // 200 us in cycles
  parameter int BLANK_CYCLES     = INT_BLANK_CYC  // 500 us in cycles
)(
  input  wire logic       core_clk,             // 100 MHz clock
  input  wire logic       rst_n,                // Async reset, active low
  input  wire logic       io_rail_undervoltage_flag, // Rail below threshold
  input  wire logic       mcu_error_input_a,    // Error signal A
  input  wire logic       mcu_error_input_b,    // Error signal B
  input  wire logic       error_reset_enable,   // Error may cause reset
  input  wire logic       other_reset_req,      // Any other reset source
  input  wire logic       wd_start_req,         // Watchdog start request
  input  wire logic       question_answer_mode, // Watchdog in QA mode
  input  wire logic       qa_monitor_started,   // QA monitoring running
  input  wire logic       wd_expired,           // Watchdog expiry pulse
  input  wire logic       wd_expiry_reset_mask, // Expiry does not reset
  input  wire logic       fail_pin_sense,       // Read-back of fail pin
  input  wire logic       ctl_pin_sense,        // Read-back of ctl pin
  input  wire logic       ind_pin_sense,        // Read-back of indicator
  input  wire logic       rst_pin_sense,        // Read-back of reset pin
  input  wire logic       reg_wr,               // Register write strobe
  input  wire logic       reg_rd,               // Register read strobe
  input  wire logic [5:0] reg_addr,             // Register address
  input  wire logic [7:0] reg_wdata,            // Register write data
  output logic      [7:0] reg_rdata,            // Register read data
  output logic            low_voltage_indicator_pin, // Indicator pin
  output logic            safety_fail_output,   // Fail pin, active low
  output logic            external_control_pin, // External control pin
  output logic            reset_output_n,       // Reset out, active low
  output logic            interrupt_output_n    // Interrupt, active low
);

  // ==========================================================
  // Register state
  logic [7:0] pin_level_r;
  logic [7:0] int_req_r;
  logic [7:0] int_req_nxt;
  logic [7:0] int_mask_r;
  logic       dummy_r;
  logic [CNT_W-1:0] blank_r;
  logic       wr_pin;
  logic       wr_clr;
  logic       wr_mask;
  logic       wr_req;

  assign wr_pin  = reg_wr && (reg_addr == ADDR_PIN_LEVEL);
  assign wr_clr  = reg_wr && (reg_addr == ADDR_INT_CLR);
  assign wr_mask = reg_wr && (reg_addr == ADDR_INT_MASK);
  assign wr_req  = reg_wr && (reg_addr == ADDR_INT_REQ);

  // Pin level and error format register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_level_r <= PIN_LEVEL_RST;
    else if (wr_pin)
      pin_level_r <= reg_wdata & PIN_LEVEL_WMASK;
  end

  // Interrupt mask register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      int_mask_r <= INT_MASK_RST;
    else if (wr_mask)
      int_mask_r <= reg_wdata & INT_USED;
  end

  // Intentional interrupt bit, the only writable request bit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dummy_r <= 1'b0;
    else if (wr_req)
      dummy_r <= reg_wdata[BIT_DUMMY];
  end

  // Registered read data, unmapped reads return zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_INT_REQ:   reg_rdata <= int_req_r;
        ADDR_INT_MASK:  reg_rdata <= int_mask_r;
        ADDR_PIN_LEVEL: reg_rdata <= pin_level_r;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Error input monitor, one channel per input
  logic [1:0] err_in;
  logic [1:0] err_det;
  logic [CNT_W-1:0] err_limit;
  logic       dyn_mode;

  assign err_in   = {mcu_error_input_b, mcu_error_input_a};
  assign dyn_mode = pin_level_r[BIT_ERR_FORMAT];
  // Expiry: static fixed short, dynamic by select bit
  assign err_limit = (dyn_mode && !pin_level_r[BIT_TOGGLE_SEL]) ?
                     CNT_W'(ERR_LONG_CYCLES) :
                     CNT_W'(ERR_SHORT_CYCLES);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_err
      logic             meta_r;
      logic             sync_r;
      logic             prev_r;
      logic             armed_r;
      logic [CNT_W-1:0] cnt_r;

      // Two-stage synchroniser and edge history
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else
        begin
          meta_r <= err_in[gi];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end

      // Arm after the input first reads high
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          armed_r <= 1'b0;
        else if (sync_r)
          armed_r <= 1'b1;
      end

      // Timeout counter, saturates at the limit
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          cnt_r <= '0;
        else if (!armed_r)
          cnt_r <= '0;
        else if (dyn_mode ? (sync_r != prev_r) : sync_r)
          cnt_r <= '0;
        else if (cnt_r < err_limit)
          cnt_r <= cnt_r + CNT_W'(1);
      end

      assign err_det[gi] = armed_r && (cnt_r >= err_limit);
    end
  endgenerate

  // ==========================================================
  // Reset output and safety-fail output
  logic any_err;
  logic expiry_reset;
  assign any_err      = |err_det;
  assign expiry_reset = wd_expired && !wd_expiry_reset_mask;

  // Reset low on a reset source or on an enabled error
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_output_n <= 1'b0;
    else
      reset_output_n <= !(other_reset_req || expiry_reset ||
                          (any_err && error_reset_enable));
  end

  // Fail pin low on error or while reset is low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      safety_fail_output <= 1'b0;
    else
      safety_fail_output <= !any_err &&
                            reset_output_n;
  end

  // ==========================================================
  // Low-voltage indicator
  logic ind_high_seen_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ind_high_seen_r <= 1'b0;
    else if (low_voltage_indicator_pin)
      ind_high_seen_r <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      low_voltage_indicator_pin <= 1'b0;
    else if (io_rail_undervoltage_flag)
      low_voltage_indicator_pin <= 1'b0;
    else if (ind_high_seen_r)
      low_voltage_indicator_pin <= pin_level_r[BIT_IND_LEVEL];
    else
      low_voltage_indicator_pin <= 1'b1;
  end

  // ==========================================================
  // External control pin follows watchdog run state
  logic wd_run_r;
  logic wd_go;
  assign wd_go = question_answer_mode ? qa_monitor_started
                                      : wd_start_req;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_run_r <= 1'b0;
    else if (!reset_output_n || wd_expired ||
             io_rail_undervoltage_flag)
      wd_run_r <= 1'b0;
    else if (wd_go)
      wd_run_r <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      external_control_pin <= 1'b0;
    else
      external_control_pin <= wd_run_r && reset_output_n &&
                              !io_rail_undervoltage_flag &&
                              pin_level_r[BIT_EXT_LEVEL];
  end

  // ==========================================================
  // Pin monitors: fault when a pin, stable for a cycle, reads back wrong
  logic [3:0] drv_now;
  logic [3:0] drv_prev_r;
  logic [3:0] sense;
  logic [3:0] pin_fault;
  assign drv_now = {safety_fail_output, external_control_pin,
                    low_voltage_indicator_pin, reset_output_n};
  assign sense   = {fail_pin_sense, ctl_pin_sense,
                    ind_pin_sense, rst_pin_sense};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      drv_prev_r <= 4'h0;
    else
      drv_prev_r <= drv_now;
  end

  assign pin_fault = (drv_now ~^ drv_prev_r) & (sense ^ drv_now);

  // ==========================================================
  // Interrupt factors: set wins over a clear in the same cycle
  always_comb
  begin
    int_req_nxt = int_req_r;
    if (wr_clr)
      int_req_nxt = int_req_nxt & ~reg_wdata;
    int_req_nxt[BIT_DUMMY] = int_req_nxt[BIT_DUMMY] | dummy_r;
    int_req_nxt[BIT_FAIL_MON:BIT_RST_MON] =
      int_req_nxt[BIT_FAIL_MON:BIT_RST_MON] | pin_fault;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      int_req_r <= INT_REQ_RST;
    else
      int_req_r <= int_req_nxt & INT_USED;
  end

  // Blanking window restarted by every clear write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      blank_r <= '0;
    else if (wr_clr)
      blank_r <= CNT_W'(BLANK_CYCLES);
    else if (blank_r != '0)
      blank_r <= blank_r - CNT_W'(1);
  end

  // Active low while an unmasked factor is latched and not blanked
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_output_n <= 1'b1;
    else
      interrupt_output_n <= !((|(int_req_r & ~int_mask_r)) &&
                              (blank_r == '0));
  end

endmodule // safety_outputs_and_interrupt

// ===== tb/mcu_host_model.sv
// Host microcontroller model driving the two error signals
`timescale 1ns/100ps

module mcu_host_model (
  input  wire logic       core_clk, // Bench clock
  input  wire logic [1:0] mode,     // 0 high, 1 low, 2 toggle
  input  wire logic [7:0] half,     // Cycles between toggles, less one
  output logic            err_a,    // Error line A
  output logic            err_b     // Error line B
);
  logic [7:0] cnt_r = 8'h00;

  // ==========================================================
  // Lines held low until told to rise
  // Toggle every half+1 cycles, inside the tolerance band
  always @(negedge core_clk)
  begin
    cnt_r <= (cnt_r >= half) ? 8'h00 : cnt_r + 8'h01;
    if (mode == 2'h0)
      err_a <= 1'b1;
    else if (mode == 2'h1)
      err_a <= 1'b0;
    else if (cnt_r >= half)
      err_a <= ~err_a;
  end

  // One monitor pin wired to both inputs
  assign err_b = err_a;
endmodule // mcu_host_model

// ===== tb/safety_outputs_and_interrupt_sva.sv
// Concurrent checks on the safety outputs and interrupt ports
`timescale 1ns/100ps

module safety_outputs_and_interrupt_sva
  import safety_out_pkg::*;
#(
  parameter int BLANK_CYCLES = INT_BLANK_CYC // Blanking window in cycles
)(
  input wire logic       core_clk,                  // Clock
  input wire logic       rst_n,                     // Reset, active low
  input wire logic       io_rail_undervoltage_flag, // Rail low
  input wire logic       other_reset_req,           // Reset source
  input wire logic       wd_expired,                // Expiry pulse
  input wire logic       reg_wr,                    // Write strobe
  input wire logic [5:0] reg_addr,                  // Register address
  input wire logic       low_voltage_indicator_pin, // Indicator
  input wire logic       safety_fail_output,        // Fail pin
  input wire logic       external_control_pin,      // Control pin
  input wire logic       reset_output_n,            // Reset out
  input wire logic       interrupt_output_n         // Interrupt out
);
  // ==========================================================
  // Pin level checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Cycles since the last clear write, saturating
  logic [15:0] clr_age;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      clr_age <= 16'hffff;
    else if (reg_wr && (reg_addr == ADDR_INT_CLR))
      clr_age <= 16'h0000;
    else if (clr_age != 16'hffff)
      clr_age <= clr_age + 16'h0001;
  end

  chk_ind_undervolt:
    assert property (io_rail_undervoltage_flag
      |-> ##[1:2] !low_voltage_indicator_pin)
    else $error("indicator high during rail undervoltage");
  chk_ctl_undervolt:
    assert property (io_rail_undervoltage_flag
      |-> ##[1:3] !external_control_pin)
    else $error("control pin high during rail undervoltage");
  chk_rst_other:
    assert property (other_reset_req |-> ##[1:2] !reset_output_n)
    else $error("reset output not low for reset source");
  chk_ctl_reset:
    assert property (!reset_output_n |-> ##[0:2] !external_control_pin)
    else $error("control pin high while reset low");
  chk_fail_in_rst:
    assert property (!reset_output_n && !$past(reset_output_n)
      |-> !safety_fail_output)
    else $error("fail output high while reset low");
  chk_ctl_expiry:
    assert property (wd_expired |-> ##[1:3] !external_control_pin)
    else $error("control pin high after expiry");
  chk_int_release:
    assert property ($rose(interrupt_output_n)
      |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt released without a write");
  chk_int_blank:
    assert property ($rose(interrupt_output_n)
      |=> interrupt_output_n [*8])
    else $error("interrupt reasserted inside blanking");
  chk_int_quiet:
    assert property ((clr_age != 16'h0000) && (clr_age <= BLANK_CYCLES)
      |-> interrupt_output_n)
    else $error("interrupt low inside the blanking window");
endmodule // safety_outputs_and_interrupt_sva

bind safety_outputs_and_interrupt safety_outputs_and_interrupt_sva
  #(.BLANK_CYCLES(BLANK_CYCLES)) chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .io_rail_undervoltage_flag(io_rail_undervoltage_flag),
  .other_reset_req(other_reset_req), .wd_expired(wd_expired),
  .low_voltage_indicator_pin(low_voltage_indicator_pin),
  .safety_fail_output(safety_fail_output),
  .external_control_pin(external_control_pin),
  .reset_output_n(reset_output_n),
  .interrupt_output_n(interrupt_output_n));

// ===== tb/safety_outputs_and_interrupt_tb_top.sv
// Self-checking bench for the safety outputs and interrupt block
`timescale 1ns/100ps

module safety_outputs_and_interrupt_tb_top;
  import safety_out_pkg::*;
  localparam int BLANK = 50;
  logic       core_clk = 1'b0, rst_n = 1'b0, uv = 1'b0, ere = 1'b0;
  logic       orr = 1'b0, wds = 1'b0, qam = 1'b0, qas = 1'b0;
  logic       wde = 1'b0, wdm = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       lk = 1'b0, rd_pend = 1'b0, lk_pend = 1'b0;
  logic       err_a, err_b, ind, fail, ctl, rstn, intn;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, half = 8'h24, reg_rdata;
  logic [1:0] mode = 2'h1;
  logic [3:0] flt = 4'h0;
  logic [31:0] seed = 32'h0000_0057, r;
  logic [9:0] pin_q[$];
  logic [7:0] reg_q[$];
  int         fail_count = 0, comparisons = 0;

  // ==========================================================
  // Clock, partner and design
  always #5 core_clk = ~core_clk;
  mcu_host_model mcu_host_model_inst (.core_clk(core_clk), .mode(mode),
    .half(half), .err_a(err_a), .err_b(err_b));
  safety_outputs_and_interrupt #(.ERR_SHORT_CYCLES(20),
    .ERR_LONG_CYCLES(40), .BLANK_CYCLES(BLANK))
  safety_outputs_and_interrupt_inst (.core_clk(core_clk), .rst_n(rst_n),
    .io_rail_undervoltage_flag(uv), .mcu_error_input_a(err_a),
    .mcu_error_input_b(err_b), .error_reset_enable(ere),
    .other_reset_req(orr), .wd_start_req(wds), .question_answer_mode(qam),
    .qa_monitor_started(qas), .wd_expired(wde), .wd_expiry_reset_mask(wdm),
    .fail_pin_sense(fail ^ flt[3]), .ctl_pin_sense(ctl ^ flt[2]),
    .ind_pin_sense(ind ^ flt[1]), .rst_pin_sense(rstn ^ flt[0]),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .low_voltage_indicator_pin(ind), .safety_fail_output(fail),
    .external_control_pin(ctl), .reset_output_n(rstn),
    .interrupt_output_n(intn));

  // ==========================================================
  // Driver tasks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(4);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_q.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
  endtask
  // Pins as {ind, fail, ctl, rstn, intn}, mask then value
  task automatic look(input logic [4:0] m, input logic [4:0] e);
    pin_q.push_back({m, e});
    lk = 1'b1;
    tick(1);
    lk = 1'b0;
    tick(1);
  endtask

  // ==========================================================
  // Watcher and compares
  task automatic cmp_reg(input logic [7:0] e);
    comparisons++;
    if (reg_rdata !== e)
    begin
      $display("unexpected reg_rdata expected %h seen %h", e, reg_rdata);
      fail_count++;
    end
  endtask
  task automatic cmp_pin(input logic [9:0] v);
    logic [4:0] p;
    p = {ind, fail, ctl, rstn, intn} & v[9:5];
    comparisons++;
    if (p !== v[4:0])
    begin
      $display("unexpected pins expected %b seen %b", v[4:0], p);
      fail_count++;
    end
  endtask
  always @(posedge core_clk)
  begin
    rd_pend <= reg_rd;
    lk_pend <= lk;
  end
  always @(negedge core_clk)
  begin
    if (rd_pend === 1'b1 && reg_q.size() > 0)
      cmp_reg(reg_q.pop_front());
    if (lk_pend === 1'b1 && pin_q.size() > 0)
      cmp_pin(pin_q.pop_front());
  end

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog on a hung run
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    tick(2);
    rst_n = 1'b1;
    tick(2);
    rd(ADDR_PIN_LEVEL, PIN_LEVEL_RST);
    rd(ADDR_INT_REQ, INT_REQ_RST);
    rd(ADDR_INT_MASK, INT_MASK_RST);
    rd(6'h3f, 8'h00); // Unmapped address reads zero
    r = xs();
    wr(ADDR_PIN_LEVEL, r[7:0]);
    rd(ADDR_PIN_LEVEL, r[7:0] & PIN_LEVEL_WMASK);
    wr(ADDR_PIN_LEVEL, PIN_LEVEL_RST);
    tick(30);
    look(5'h1f, 5'h1b);
    // Static format errors
    mode = 2'h0;
    tick(5);
    mode = 2'h1;
    tick(3 + int'(xs() % 12));
    mode = 2'h0;
    tick(5);
    look(5'h08, 5'h08);
    mode = 2'h1;
    tick(30);
    look(5'h0a, 5'h02);
    ere = 1'b1;
    tick(4);
    look(5'h0a, 5'h00);
    mode = 2'h0;
    ere = 1'b0;
    tick(6);
    look(5'h0a, 5'h0a);
    // External control pin
    pulse(wds);
    look(5'h04, 5'h04);
    wr(ADDR_PIN_LEVEL, 8'h20);
    tick(3);
    look(5'h04, 5'h00);
    wr(ADDR_PIN_LEVEL, PIN_LEVEL_RST);
    tick(3);
    look(5'h04, 5'h04);
    wdm = 1'b1;
    pulse(wde);
    look(5'h06, 5'h02);
    pulse(wds);
    look(5'h04, 5'h04);
    uv = 1'b1;
    tick(5);
    look(5'h14, 5'h00);
    uv = 1'b0;
    tick(5);
    look(5'h10, 5'h10);
    qam = 1'b1;
    orr = 1'b1;
    tick(4);
    look(5'h0e, 5'h00);
    orr = 1'b0;
    tick(4);
    pulse(wds);
    look(5'h04, 5'h00);
    pulse(qas);
    look(5'h04, 5'h04);
    qam = 1'b0;
    wdm = 1'b0;
    // Dynamic format, both timeouts
    mode = 2'h2;
    wr(ADDR_PIN_LEVEL, 8'h31);
    tick(80);
    look(5'h08, 5'h08);
    @(err_a);
    mode = 2'h0;
    tick(30);
    look(5'h08, 5'h08);
    tick(25);
    look(5'h08, 5'h00);
    mode = 2'h2;
    tick(50);
    look(5'h08, 5'h08);
    wr(ADDR_PIN_LEVEL, 8'h33);
    @(err_a);
    mode = 2'h0;
    tick(26);
    look(5'h08, 5'h00);
    mode = 2'h2;
    tick(30);
    wr(ADDR_PIN_LEVEL, PIN_LEVEL_RST);
    mode = 2'h0;
    // Interrupt latch, clear, mask and blanking
    wr(ADDR_INT_REQ, 8'h80);
    tick(4);
    look(5'h01, 5'h00);
    rd(ADDR_INT_REQ, 8'h80);
    wr(ADDR_INT_REQ, 8'h00);
    wr(ADDR_INT_CLR, 8'h80);
    tick(2);
    look(5'h01, 5'h01);
    rd(ADDR_INT_REQ, 8'h00);
    wr(ADDR_INT_MASK, 8'h80);
    tick(BLANK + 10);
    wr(ADDR_INT_REQ, 8'h80);
    tick(4);
    look(5'h01, 5'h01);
    rd(ADDR_INT_REQ, 8'h80);
    wr(ADDR_INT_MASK, 8'h00);
    tick(3);
    look(5'h01, 5'h00);
    wr(ADDR_INT_CLR, 8'h80);
    tick(BLANK / 2);
    look(5'h01, 5'h01);
    tick(BLANK / 2 + 15);
    look(5'h01, 5'h00);
    wr(ADDR_INT_REQ, 8'h00);
    wr(ADDR_INT_CLR, 8'h80);
    tick(BLANK + 10);
    // Pin read-back faults, one monitor at a time
    for (int i = 0; i < 4; i++)
    begin
      flt = 4'h1 << i;
      tick(6);
      flt = 4'h0;
      rd(ADDR_INT_REQ, 8'h01 << i);
      wr(ADDR_INT_CLR, 8'h01 << i);
      tick(BLANK + 10);
    end
    report_and_stop();
  end
endmodule // safety_outputs_and_interrupt_tb_top
